// ===== logic/rsf_pkg.sv
// Shared constants for the remote input status flag block.
// Assumes a 32-bit APB register bus and 16-bit remote register words.
package rsf_pkg;

  // Register byte offsets
  localparam logic [7:0] ADDR_DRIVE_STAT = 8'h00;
  localparam logic [7:0] ADDR_TERM_VEC   = 8'h04;
  localparam logic [7:0] ADDR_TERM_SEL   = 8'h08;
  localparam logic [7:0] ADDR_MON_VALUE  = 8'h0c;
  localparam logic [7:0] ADDR_JOB_INFO   = 8'h10;
  localparam logic [7:0] ADDR_JOB_DONE   = 8'h14;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h18;
  localparam logic [7:0] ADDR_IRQ_MASK   = 8'h1c;
  localparam logic [7:0] ADDR_LINK_IN    = 8'h20;

  // Drive status register fields
  localparam int DS_FWD     = 0;
  localparam int DS_REV     = 1;
  localparam int DS_INIT    = 2;
  localparam int DS_PROTECT = 3;

  // Job completion register fields
  localparam int JD_DONE    = 0;
  localparam int JD_FAIL    = 1;
  localparam int JD_REPLY_LO = 16;

  // Interrupt status bits
  localparam int IRQ_MON_ON   = 0;
  localparam int IRQ_MON_OFF  = 1;
  localparam int IRQ_JOB      = 2;
  localparam int IRQ_FLT_RST  = 3;
  localparam int IRQ_WIDTH    = 4;

  // Remote input bit positions
  localparam int RX_FWD       = 0;
  localparam int RX_REV       = 1;
  localparam int RX_TERM_LO   = 2;
  localparam int RX_MON       = 12;
  localparam int RX_RAM_DONE  = 13;
  localparam int RX_NV_DONE   = 14;
  localparam int RX_EXEC_DONE = 15;
  localparam int RX_RSV_LO    = 16;
  localparam int RX_RSV_HI    = 25;
  localparam int RX_FAULT     = 26;
  localparam int RX_READY     = 27;

  // Widths and reset values
  localparam int TERM_N       = 6;
  localparam int SEL_W        = 5;
  localparam logic [15:0] REPLY_FAIL_DEFAULT = 16'h0001;
  localparam logic [29:0] TERM_SEL_RESET = 30'h0a418820;

  typedef enum logic [1:0] {
    JOB_IDLE = 2'b00,
    JOB_BUSY = 2'b01,
    JOB_DONE = 2'b11
  } rsf_job_state_e;

  typedef enum logic [1:0] {
    KIND_NONE = 2'b00,
    KIND_RAM  = 2'b01,
    KIND_NV   = 2'b10,
    KIND_EXEC = 2'b11
  } rsf_job_kind_e;

  // Selector field i of the terminal select register
  function automatic logic [4:0] sel_field(input logic [29:0] sel,
                                           input int i);
    sel_field = sel[i*SEL_W +: SEL_W];
  endfunction

endpackage

// ===== logic/rsf_term_mux.sv
// Terminal function mapper: six remote bits, each a selectable function.
// Assumes the function vector is kept current by drive firmware.
`timescale 1ns/10ps
`default_nettype none
module rsf_term_mux (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [31:0] term_vec,
  input  wire logic [29:0] term_sel,
  output logic [5:0]       term_bits
);

  typedef struct packed {
    logic [5:0] bits;
  } rsf_mux_s;

  rsf_mux_s st_r;
  rsf_mux_s st_nxt;

  // One selector per remote bit, like output terminal parameters
  always_comb begin
    st_nxt = st_r;
    for (int i = 0; i < rsf_pkg::TERM_N; i++) begin
      st_nxt.bits[i] = term_vec[rsf_pkg::sel_field(term_sel, i)];
    end
  end

  // Registered so the remote image changes on clock edges only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign term_bits = st_r.bits;

endmodule // rsf_term_mux
`default_nettype wire

// ===== logic/rsf_status_flags.sv
// Remote input status flags and completion handshakes toward the master.
// Assumes master request bits are synchronous to pclk and that drive
// firmware services requests over APB.
// What this block does
// - Forward bit only while running forward.
// - Reverse bit only while running reverse.
// - Bits two to seven follow selected functions.
// - Monitoring flag after monitor value loaded.
// - Monitoring flag drops with monitor request.
// - RAM write done flag until command drops.
// - Nonvolatile write done flag until command drops.
// - Execution done flag after instruction finishes.
// - Fault flag on protective function.
// - Ready flag after initial setup completes.
// - Ready flag drops on protective function.
// - Reserved input bits stay zero.
// - Monitor value refreshed while request holds.
// - Fault reset request resets drive, clears fault.
// - Simultaneous write/execute requests run one only.
// - Failed execution loads nonzero reply code.
//
// Register access over APB and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module rsf_status_flags (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        monitor_request,
  input  wire logic        freq_ram_write_cmd,
  input  wire logic        freq_nv_write_cmd,
  input  wire logic        instr_exec_request,
  input  wire logic        fault_reset_request,
  input  wire logic [15:0] set_frequency_word,
  input  wire logic [15:0] instr_code_word,
  output logic [31:0]      remote_in_bits,
  output logic [15:0]      first_monitor_word,
  output logic [15:0]      reply_code_word,
  output logic             drive_reset,
  output logic             irq
);

  typedef struct packed {
    logic [3:0]                 drive_stat;
    logic [31:0]                term_vec;
    logic [29:0]                term_sel;
    logic [15:0]                mon_value;
    logic                       mon_loaded;
    logic [15:0]                mon_word;
    rsf_pkg::rsf_job_state_e    job_state;
    rsf_pkg::rsf_job_kind_e     job_kind;
    logic [15:0]                job_word;
    logic [15:0]                reply;
    logic                       fault;
    logic                       init_seen;
    logic                       prot_q;
    logic                       mon_req_q;
    logic                       flt_req_q;
    logic                       drv_rst;
    logic [3:0]                 irq_status;
    logic [3:0]                 irq_mask;
    logic                       irq;
    logic [31:0]                rx;
    logic [31:0]                rdata;
    logic                       ready;
    logic                       slverr;
  } rsf_state_s;

  rsf_state_s  st_r;
  rsf_state_s  st_nxt;
  logic [5:0]  term_bits;

  // Register read value for one address
  function automatic logic [31:0] read_mux(input rsf_state_s s,
                                           input logic [7:0] a,
                                           input logic [4:0] link);
    case (a)
      rsf_pkg::ADDR_DRIVE_STAT: read_mux = {28'h0000000, s.drive_stat};
      rsf_pkg::ADDR_TERM_VEC:   read_mux = s.term_vec;
      rsf_pkg::ADDR_TERM_SEL:   read_mux = {2'h0, s.term_sel};
      rsf_pkg::ADDR_MON_VALUE:  read_mux = {16'h0000, s.mon_value};
      rsf_pkg::ADDR_JOB_INFO:   read_mux = {s.job_word, 12'h000,
                                            s.job_state, s.job_kind};
      rsf_pkg::ADDR_IRQ_STATUS: read_mux = {28'h0000000, s.irq_status};
      rsf_pkg::ADDR_IRQ_MASK:   read_mux = {28'h0000000, s.irq_mask};
      rsf_pkg::ADDR_LINK_IN:    read_mux = {27'h0, link};
      default:                  read_mux = 32'h00000000;
    endcase
  endfunction

  // True for any offset that decodes to a register
  function automatic logic addr_ok(input logic [7:0] a);
    case (a)
      rsf_pkg::ADDR_DRIVE_STAT, rsf_pkg::ADDR_TERM_VEC,
      rsf_pkg::ADDR_TERM_SEL, rsf_pkg::ADDR_MON_VALUE,
      rsf_pkg::ADDR_JOB_INFO, rsf_pkg::ADDR_JOB_DONE,
      rsf_pkg::ADDR_IRQ_STATUS, rsf_pkg::ADDR_IRQ_MASK,
      rsf_pkg::ADDR_LINK_IN:    addr_ok = 1'b1;
      default:                  addr_ok = 1'b0;
    endcase
  endfunction

  // Whether the command behind a job is still raised
  function automatic logic job_cmd(input rsf_pkg::rsf_job_kind_e k,
                                   input logic ram,
                                   input logic nv,
                                   input logic ex);
    case (k)
      rsf_pkg::KIND_RAM:  job_cmd = ram;
      rsf_pkg::KIND_NV:   job_cmd = nv;
      rsf_pkg::KIND_EXEC: job_cmd = ex;
      default:            job_cmd = 1'b0;
    endcase
  endfunction

  rsf_term_mux u_term_mux (
    .pclk      (pclk),
    .presetn   (presetn),
    .term_vec  (st_r.term_vec),
    .term_sel  (st_r.term_sel),
    .term_bits (term_bits)
  );

  always_comb begin
    logic       setup;
    logic       wr;
    logic       cmd_up;
    logic [3:0] ev;
    logic [4:0] link;
    logic [15:0] rc;
    setup  = 1'b0;
    wr     = 1'b0;
    cmd_up = 1'b0;
    ev     = 4'h0;
    link   = {fault_reset_request, instr_exec_request, freq_nv_write_cmd,
              freq_ram_write_cmd, monitor_request};
    rc     = 16'h0000;
    st_nxt = st_r;

    // APB: answer prepared in setup, zero wait states in access
    setup = psel && !penable;
    wr    = psel && penable && st_r.ready && pwrite;
    st_nxt.ready  = setup;
    st_nxt.slverr = setup && !addr_ok(paddr);
    st_nxt.rdata  = (setup && !pwrite) ? read_mux(st_r, paddr, link)
                                       : 32'h00000000;

    // Plain software-writable registers
    if (wr && paddr == rsf_pkg::ADDR_DRIVE_STAT) begin
      st_nxt.drive_stat = pwdata[3:0];
    end
    if (wr && paddr == rsf_pkg::ADDR_TERM_VEC) begin
      st_nxt.term_vec = pwdata;
    end
    if (wr && paddr == rsf_pkg::ADDR_TERM_SEL) begin
      st_nxt.term_sel = pwdata[29:0];
    end
    if (wr && paddr == rsf_pkg::ADDR_IRQ_MASK) begin
      st_nxt.irq_mask = pwdata[3:0];
    end

    // Monitor handshake; output word refreshed every cycle while on
    if (wr && paddr == rsf_pkg::ADDR_MON_VALUE) begin
      st_nxt.mon_value = pwdata[15:0];
    end
    if (!monitor_request) begin
      st_nxt.mon_loaded = 1'b0;
    end else if (wr && paddr == rsf_pkg::ADDR_MON_VALUE) begin
      st_nxt.mon_loaded = 1'b1;
      st_nxt.mon_word   = pwdata[15:0];
    end else if (st_r.mon_loaded) begin
      st_nxt.mon_word   = st_r.mon_value;
    end
    st_nxt.mon_req_q = monitor_request;
    ev[rsf_pkg::IRQ_MON_ON]  = monitor_request && !st_r.mon_req_q;
    ev[rsf_pkg::IRQ_MON_OFF] = !monitor_request && st_r.mon_req_q;

    // One job at a time; fixed priority RAM, nonvolatile, execute
    case (st_r.job_state)
      rsf_pkg::JOB_IDLE: begin
        if (freq_ram_write_cmd) begin
          st_nxt.job_kind = rsf_pkg::KIND_RAM;
          st_nxt.job_word = set_frequency_word;
          cmd_up          = 1'b1;
        end else if (freq_nv_write_cmd) begin
          st_nxt.job_kind = rsf_pkg::KIND_NV;
          st_nxt.job_word = set_frequency_word;
          cmd_up          = 1'b1;
        end else if (instr_exec_request) begin
          st_nxt.job_kind = rsf_pkg::KIND_EXEC;
          st_nxt.job_word = instr_code_word;
          cmd_up          = 1'b1;
        end
        if (cmd_up) begin
          st_nxt.job_state = rsf_pkg::JOB_BUSY;
        end
      end
      rsf_pkg::JOB_BUSY: begin
        if (!job_cmd(st_r.job_kind, freq_ram_write_cmd,
                     freq_nv_write_cmd, instr_exec_request)) begin
          // Withdrawn before firmware finished: drop the job
          st_nxt.job_state = rsf_pkg::JOB_IDLE;
          st_nxt.job_kind  = rsf_pkg::KIND_NONE;
        end else if (wr && paddr == rsf_pkg::ADDR_JOB_DONE &&
                     pwdata[rsf_pkg::JD_DONE]) begin
          rc = pwdata[rsf_pkg::JD_REPLY_LO +: 16];
          if (pwdata[rsf_pkg::JD_FAIL] && rc == 16'h0000) begin
            rc = rsf_pkg::REPLY_FAIL_DEFAULT;
          end
          st_nxt.reply     = rc;
          st_nxt.job_state = rsf_pkg::JOB_DONE;
        end
      end
      rsf_pkg::JOB_DONE: begin
        if (!job_cmd(st_r.job_kind, freq_ram_write_cmd,
                     freq_nv_write_cmd, instr_exec_request)) begin
          st_nxt.job_state = rsf_pkg::JOB_IDLE;
          st_nxt.job_kind  = rsf_pkg::KIND_NONE;
        end
      end
      default: begin
        st_nxt.job_state = rsf_pkg::JOB_IDLE;
        st_nxt.job_kind  = rsf_pkg::KIND_NONE;
      end
    endcase
    ev[rsf_pkg::IRQ_JOB] = cmd_up;

    // Fault latch: protective trip sets, master reset request clears
    st_nxt.prot_q    = st_r.drive_stat[rsf_pkg::DS_PROTECT];
    st_nxt.flt_req_q = fault_reset_request;
    st_nxt.drv_rst   = 1'b0;
    if (fault_reset_request && !st_r.flt_req_q && st_r.fault) begin
      st_nxt.fault   = 1'b0;
      st_nxt.drv_rst = 1'b1;
      st_nxt.drive_stat[rsf_pkg::DS_PROTECT] = 1'b0;
      ev[rsf_pkg::IRQ_FLT_RST] = 1'b1;
    end
    // A new trip in the same cycle wins over the reset
    if (st_r.drive_stat[rsf_pkg::DS_PROTECT] && !st_r.prot_q) begin
      st_nxt.fault = 1'b1;
    end
    if (st_r.drive_stat[rsf_pkg::DS_INIT]) begin
      st_nxt.init_seen = 1'b1;
    end

    // Sticky status, write one to clear, new events win
    if (wr && paddr == rsf_pkg::ADDR_IRQ_STATUS) begin
      st_nxt.irq_status = st_r.irq_status & ~pwdata[3:0];
    end
    st_nxt.irq_status = st_nxt.irq_status | ev;
    st_nxt.irq        = |(st_r.irq_status & st_r.irq_mask);

    // Remote input image toward the master
    st_nxt.rx = 32'h00000000;
    st_nxt.rx[rsf_pkg::RX_FWD] = st_r.drive_stat[rsf_pkg::DS_FWD] &&
                                 !st_r.drive_stat[rsf_pkg::DS_REV];
    st_nxt.rx[rsf_pkg::RX_REV] = st_r.drive_stat[rsf_pkg::DS_REV] &&
                                 !st_r.drive_stat[rsf_pkg::DS_FWD];
    st_nxt.rx[rsf_pkg::RX_TERM_LO +: rsf_pkg::TERM_N] = term_bits;
    st_nxt.rx[rsf_pkg::RX_MON] = monitor_request &&
                                 st_r.mon_loaded;
    st_nxt.rx[rsf_pkg::RX_RAM_DONE] =
      st_r.job_state == rsf_pkg::JOB_DONE &&
      st_r.job_kind == rsf_pkg::KIND_RAM && freq_ram_write_cmd;
    st_nxt.rx[rsf_pkg::RX_NV_DONE] =
      st_r.job_state == rsf_pkg::JOB_DONE &&
      st_r.job_kind == rsf_pkg::KIND_NV && freq_nv_write_cmd;
    st_nxt.rx[rsf_pkg::RX_EXEC_DONE] =
      st_r.job_state == rsf_pkg::JOB_DONE &&
      st_r.job_kind == rsf_pkg::KIND_EXEC &&
      instr_exec_request;
    st_nxt.rx[rsf_pkg::RX_FAULT] = st_r.fault;
    // Master interlocks on this bit, so it drops on any trip
    st_nxt.rx[rsf_pkg::RX_READY] = st_r.init_seen &&
                                   !st_r.fault;
  end

  // Single state register for the block; the terminal mapper keeps its own
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r          <= '0;
      st_r.term_sel <= rsf_pkg::TERM_SEL_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Every output straight from a flip-flop
  assign prdata             = st_r.rdata;
  assign pready             = st_r.ready;
  assign pslverr            = st_r.slverr;
  assign remote_in_bits     = st_r.rx;
  assign first_monitor_word = st_r.mon_word;
  assign reply_code_word    = st_r.reply;
  assign drive_reset        = st_r.drv_rst;
  assign irq                = st_r.irq;

endmodule // rsf_status_flags
`default_nettype wire

// ===== verif/rsf_master_model.sv
// Network master model: turns bench wishes into level requests.
// Assumes the bench holds each wish until its handshake is seen.
`timescale 1ns/10ps
`default_nettype none
module rsf_master_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       ready,
  input  wire logic [4:0] want,
  output logic [4:0]      req
);
  // Jobs wait for ready; fault reset must pass while station is down
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) req <= 5'h00;
    else req <= {want[4], want[3:0] & {4{ready}}};
  end
endmodule // rsf_master_model
`default_nettype wire

// ===== verif/rsf_status_flags_sva.sv
// Checker for the remote image and its handshakes.
// Assumes one pclk domain and the one-cycle image lag of the design.
`timescale 1ns/10ps
`default_nettype none
module rsf_status_flags_sva (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        monitor_request,
  input wire logic        freq_ram_write_cmd,
  input wire logic        freq_nv_write_cmd,
  input wire logic        instr_exec_request,
  input wire logic [31:0] remote_in_bits,
  input wire logic        drive_reset
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Short alias for the image
  wire logic [31:0] rb;
  assign rb = remote_in_bits;
  a_rsv_bits_zero: assert property (rb[25:16] == 10'h000)
    else $error("reserved image bits set");
  a_dir_exclusive: assert property (!(rb[0] && rb[1]))
    else $error("forward and reverse both set");
  a_mon_drop: assert property (!monitor_request |=> !rb[12])
    else $error("monitoring flag outlived request");
  a_ram_done_drop: assert property (!freq_ram_write_cmd |=> !rb[13])
    else $error("ram done outlived command");
  a_nv_done_drop: assert property (!freq_nv_write_cmd |=> !rb[14])
    else $error("nv done outlived command");
  a_exec_done_drop: assert property (!instr_exec_request |=> !rb[15])
    else $error("exec done outlived request");
  a_fault_unready: assert property (rb[26] |-> !rb[27])
    else $error("ready while faulted");
  a_reset_clears: assert property (drive_reset |-> ##[0:2] !rb[26])
    else $error("fault kept after drive reset");
  a_reset_pulse: assert property (drive_reset |=> !drive_reset)
    else $error("drive reset longer than a cycle");
endmodule // rsf_status_flags_sva
bind rsf_status_flags rsf_status_flags_sva i_sva (.pclk(pclk),
  .presetn(presetn), .monitor_request(monitor_request),
  .freq_ram_write_cmd(freq_ram_write_cmd),
  .freq_nv_write_cmd(freq_nv_write_cmd),
  .instr_exec_request(instr_exec_request),
  .remote_in_bits(remote_in_bits), .drive_reset(drive_reset));
`default_nettype wire

// ===== verif/rsf_status_flags_tb.sv
// Self-checking bench for the remote input status flag block.
// Assumes the master model in front of the request inputs.
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) chk((g) === (e), `__LINE__)
module rsf_status_flags_tb;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rib, rd, tv, ts;
  logic        pready, pslverr, drive_reset, irq, err;
  logic [15:0] fmw, rcw, sfw = 16'h0, icw = 16'h0, mv;
  logic [4:0]  want = 5'h00, req;
  logic [5:0]  et;
  logic [33:0] obs;
  int          num_errors = 0, total_checks = 0;
  assign obs = {irq, drive_reset, rib};
  // 50 MHz clock
  always #10 pclk = ~pclk;
  rsf_master_model i_mst (.pclk(pclk), .presetn(presetn),
    .ready(rib[27]), .want(want), .req(req));
  rsf_status_flags i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .monitor_request(req[0]), .freq_ram_write_cmd(req[1]),
    .freq_nv_write_cmd(req[2]), .instr_exec_request(req[3]),
    .fault_reset_request(req[4]), .set_frequency_word(sfw),
    .instr_code_word(icw), .remote_in_bits(rib),
    .first_monitor_word(fmw), .reply_code_word(rcw),
    .drive_reset(drive_reset), .irq(irq));
  task automatic chk(input bit ok, input int ln);
    total_checks++;
    if (!ok) begin
      num_errors++;
      $display("unexpected at %0t: mismatch, line %0d", $time, ln);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d, errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic hang;
    num_errors++;
    $display("unexpected at %0t: wait ran out", $time);
    complete_run();
  endtask
  // One APB transfer; pready and read data taken at the rising edge
  task automatic apb(input bit w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
    if (n >= 20) hang();
    rd = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
  endtask
  // Bounded wait for one observed bit
  task automatic wbit(input int i, input logic v);
    int n;
    n = 0;
    do begin @(negedge pclk); n++; end while (obs[i] !== v && n < 40);
    if (n >= 40) hang();
    `CHK(obs[i], v);
  endtask
  task automatic setw(input logic [4:0] w, input logic [15:0] f);
    @(posedge pclk);
    want <= w; sfw <= f; icw <= ~f;
  endtask
  task automatic settle(input int n);
    repeat (n) @(negedge pclk);
  endtask
  // Main sequence: reset, then one section per behaviour
  initial begin
    tv = $urandom(32'hf3b3e158);
    repeat (16) @(posedge pclk);
    presetn <= 1;
    settle(1);
    `CHK(rib, 32'h0);
    apb(0, 8'h08, 0);
    `CHK(rd[29:0], 30'h0a418820);
    apb(1, 8'h00, 32'h4);
    wbit(27, 1);
    for (int v = 0; v < 4; v++) begin
      apb(1, 8'h00, 32'(4 + v));
      settle(3);
      `CHK(rib[1:0], (v == 3) ? 2'b00 : 2'(v));
    end
    $display("test direction done");
    for (int k = 0; k < 5; k++) begin
      tv = (k == 0) ? 32'h80000000 : $urandom;
      ts = (k == 0) ? 32'h3fffffff : $urandom & 32'h3fffffff;
      apb(1, 8'h04, tv);
      apb(1, 8'h08, ts);
      settle(4);
      for (int i = 0; i < 6; i++) et[i] = tv[ts[i*5 +: 5]];
      `CHK(rib[7:2], et);
    end
    $display("test terminals done");
    apb(1, 8'h1c, 32'h1);
    mv = 16'($urandom);
    setw(5'h01, 0);
    wbit(33, 1);
    `CHK(rib[12], 1'b0);
    apb(1, 8'h0c, {16'h0, mv});
    wbit(12, 1);
    `CHK(fmw, mv);
    apb(1, 8'h0c, {16'h0, ~mv});
    settle(2);
    `CHK(fmw, ~mv);
    apb(1, 8'h18, 32'hf);
    settle(2);
    `CHK(irq, 1'b0);
    setw(5'h00, 0);
    wbit(12, 0);
    $display("test monitor done");
    for (int k = 1; k < 4; k++) begin
      mv = 16'($urandom);
      setw(5'(1 << k), mv);
      settle(2);
      apb(0, 8'h10, 0);
      `CHK(rd[3:0], {2'b01, 2'(k)});
      `CHK(rd[31:16], (k == 3) ? ~mv : mv);
      apb(1, 8'h14, (k == 3) ? 32'h3 : {mv, 16'h1});
      wbit(12 + k, 1);
      `CHK(rcw, (k == 3) ? 16'h0001 : mv);
      setw(5'h00, 0);
      wbit(12 + k, 0);
    end
    // Withdrawn before firmware finishes: job dropped, no done bit
    setw(5'h04, 16'h55aa);
    settle(2);
    apb(0, 8'h20, 0);
    `CHK(rd[4:0], 5'h04);
    setw(5'h00, 0);
    settle(3);
    apb(0, 8'h10, 0);
    `CHK(rd[3:0], 4'h0);
    `CHK(rib[14], 1'b0);
    setw(5'h0e, 16'h1234);
    settle(2);
    apb(0, 8'h10, 0);
    `CHK(rd[1:0], 2'b01);
    apb(1, 8'h14, 32'h1);
    wbit(13, 1);
    `CHK(rib[15:14], 2'b00);
    setw(5'h00, 0);
    wbit(13, 0);
    $display("test jobs done");
    apb(1, 8'h1c, 32'h8);
    apb(1, 8'h00, 32'hc);
    wbit(26, 1);
    `CHK(rib[27], 1'b0);
    setw(5'h10, 0);
    wbit(32, 1);
    wbit(26, 0);
    wbit(27, 1);
    wbit(33, 1);
    setw(5'h00, 0);
    apb(0, 8'h40, 0);
    `CHK({err, rd}, {1'b1, 32'h0});
    $display("test fault done");
    complete_run();
  end
endmodule // rsf_status_flags_tb
`default_nettype wire
